// *** oscref_clk_meter.sv ***
// far-side model: a clock receiver that measures period and high time
`timescale 1ns/1ps
module oscref_clk_meter
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       sig_i,
  output logic      [7:0] per_o,
  output logic      [7:0] hi_o
);
  logic [7:0] cnt;
  logic [7:0] hcnt;
  logic       prev;
  // a rise closes one period; values hold until the next rise
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {per_o, hi_o, cnt, hcnt, prev} <= '0;
    end
    else
    begin
      prev <= sig_i;
      if (sig_i && !prev)
      begin
        per_o <= cnt;
        hi_o  <= hcnt;
        cnt   <= 8'h01;
        hcnt  <= 8'h01;
      end
      else
      begin
        cnt  <= cnt + 8'h01;
        hcnt <= hcnt + {7'h00, sig_i};
      end
    end
  end
endmodule // oscref_clk_meter

// *** oscref_ctrl.sv ***
// oscillator control and status registers with reference clock generator
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "oscref_regs.svh"

// Contract
// R1 - config PLL enable set: ignore software PLL bit, keep 4x PLL on.
// R2 - config PLL enable clear: software PLL bit turns 4x PLL on or off.
// R3 - frequency codes 1111 to 1000 select the high-frequency source.
// R4 - codes 0111,0110,0101,0100,0010 select medium-frequency source; reset loads 0111.
// R5 - code 0011 is 31.25 kHz from high-frequency; 000x selects low-frequency oscillator.
// R6 - clock select 1x internal, 01 Timer1, 00 the configured oscillator.
// R7 - Timer1 ready flag follows oscillator when enabled, reads 1 when disabled.
// R8 - PLL ready flag reads 1 when the 4x PLL is ready.
// R9 - start-up status reads 1 when running from the configured clock.
// R10 - high, medium, low oscillator ready flags are read-only status.
// R11 - locked flag means within 2 percent, stable flag within 0.5 percent.
// R12 - 6-bit tuning is a signed offset around the calibrated frequency.
// R13 - reference clock comes from system clock, feeds pin and modulator.
// R14 - unit runs while enabled; pin driven only when output enable also set.
// R15 - divider select offers eight divide options.
// R16 - undivided clock keeps source duty unless 0 percent is chosen.
// R17 - divide-by-two 25 and 75 percent duty limited by source duty.
// R18 - slew limiting active while the slew bit is set.
// R19 - any reset disables the unit and restores control defaults.
// R20 - crystal modes keep the pin for the oscillator; modulator still fed.
// R21 - clock-out config puts instruction clock on pin, overriding reference clock.
// R22 - in Sleep the unit stops and outputs hold their levels.
// R23 - divider 000 undivided, 001 to 111 divide by 2 through 128.
// R24 - duty codes 00,01,10,11 give 0, 25, 50, 75 percent.
// R25 - modulator clock held low when disabled or at 0 percent duty.
module oscref_ctrl
  import oscref_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  // classic wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // configuration word bits
  input  wire logic              config_pll_enable_i,
  input  wire logic              config_clock_out_enable_i,
  input  wire logic [2:0]        config_osc_mode_i,
  // oscillator condition and sleep
  input  wire oscref_osc_state_t osc_state_i,
  input  wire logic              sleep_i,
  // clock selection and reference clock outputs
  output oscref_clk_sel_t        clk_sel_o,
  output logic                   reference_clock_pin_o,
  output logic                   reference_clock_pin_oe_o,
  output logic                   refclk_slew_limit_o,
  output logic                   modulator_clk_o
);

  // register state
  logic [7:0] osc_control;
  logic [7:0] osc_tuning;
  logic [7:0] refclk_control;
  logic [7:0] aux_control;
  logic [7:0] osc_status;

  // bus decode
  wire        bus_req     = wb_cyc_i & wb_stb_i;
  wire        bus_wr      = bus_req & wb_we_i & wb_sel_i[0] & ~wb_ack_o;
  wire [7:0]  word_adr    = {wb_adr_i[7:2], 2'b00};
  wire        hit_control = (word_adr == `OSCREF_OFS_CONTROL);
  wire        hit_status  = (word_adr == `OSCREF_OFS_STATUS);
  wire        hit_tuning  = (word_adr == `OSCREF_OFS_TUNING);
  wire        hit_refclk  = (word_adr == `OSCREF_OFS_REFCLK);
  wire        hit_aux     = (word_adr == `OSCREF_OFS_AUX);
  wire [7:0]  wr_byte     = wb_dat_i[7:0];

  // read mux; unmapped words read as zero but are still acknowledged
  wire [7:0]  rd_byte = hit_control ? osc_control :
                        hit_status  ? osc_status :
                        hit_tuning  ? osc_tuning :
                        hit_refclk  ? refclk_control :
                        hit_aux     ? aux_control : 8'h00;

  // one-cycle registered ack; the !ack term drops it in the following cycle
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // writable registers; any reset restores defaults
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      osc_control    <= `OSCREF_RST_CONTROL; // R4
      osc_tuning     <= `OSCREF_RST_TUNING;
      refclk_control <= `OSCREF_RST_REFCLK; // R19
      aux_control    <= `OSCREF_RST_AUX;
    end
    else
    begin
      if (bus_wr && hit_control)
        osc_control <= wr_byte & `OSCREF_CTL_MASK;
      if (bus_wr && hit_tuning)
        osc_tuning <= wr_byte & `OSCREF_TUN_MASK; // R12
      if (bus_wr && hit_refclk)
        refclk_control <= wr_byte;
      if (bus_wr && hit_aux)
        aux_control <= wr_byte & `OSCREF_AUX_MASK;
    end
  end

  // control fields
  wire       soft_pll   = osc_control[`OSCREF_CTL_SPLL];
  wire [3:0] freq_code  = osc_control[`OSCREF_CTL_FREQ_HI:`OSCREF_CTL_FREQ_LO];
  wire [1:0] clk_select = osc_control[`OSCREF_CTL_SCS_HI:`OSCREF_CTL_SCS_LO];
  wire       t1_enable  = aux_control[`OSCREF_AUX_T1EN];
  wire       ref_en     = refclk_control[`OSCREF_REF_EN];
  wire       ref_oe     = refclk_control[`OSCREF_REF_OE];
  wire [1:0] ref_dc     = refclk_control[`OSCREF_REF_DC_HI:`OSCREF_REF_DC_LO];
  wire [2:0] ref_div    = refclk_control[`OSCREF_REF_DIV_HI:`OSCREF_REF_DIV_LO];

  // config bit overrides the software bit
  wire pll_enable = config_pll_enable_i | soft_pll; // R1 R2

  // source decode; 0011 is an hf-derived duplicate, 000x is the lf oscillator
  wire freq_is_hf = freq_code[3] | (freq_code == `OSCREF_FREQ_HF_31K); // R3 R5
  wire freq_is_lf = (freq_code[3:1] == 3'b000); // R5
  oscref_int_src_t int_src;
  assign int_src = freq_is_hf ? OSCREF_INT_HF :
                   freq_is_lf ? OSCREF_INT_LF : OSCREF_INT_MF; // R4

  oscref_sys_src_t sys_src;
  assign sys_src = clk_select[1] ? OSCREF_SRC_INTOSC :
                   clk_select[0] ? OSCREF_SRC_TIMER1 : OSCREF_SRC_CONFIG; // R6

  // clock tree selection; pll ready only counts while the pll is enabled
  assign clk_sel_o = '{sys_src:            sys_src,
                       int_src:            int_src,
                       freq_code:          freq_code,
                       pll_enable:         pll_enable,
                       freq_tuning_offset: osc_tuning[5:0]}; // R12

  // status register view, read-only
  assign osc_status = {t1_enable ? osc_state_i.timer1_osc_ready : 1'b1, // R7
                       pll_enable & osc_state_i.pll_locked, // R8
                       osc_state_i.on_config_clock, // R9
                       osc_state_i.high_freq_osc_ready, // R10
                       osc_state_i.high_freq_osc_locked, // R11
                       osc_state_i.mid_freq_osc_ready, // R10
                       osc_state_i.low_freq_osc_ready, // R10
                       osc_state_i.high_freq_osc_stable}; // R11

  // reference divider: period is 2^div system clocks
  logic [6:0] ref_cnt;
  logic       ref_q;
  wire  [7:0] div_len  = 8'h01 << ref_div; // R15 R23
  wire  [7:0] div_last = div_len - 8'h01;
  wire  [8:0] duty_mul = {1'b0, div_len} * {7'h00, ref_dc}; // R24
  wire  [8:0] duty_raw = duty_mul >> 2;
  // at divide-by-two a quarter period is below one clock, so 25 rounds up
  wire  [8:0] duty_thr = (ref_dc != 2'b00 && duty_raw == 9'h000) ? 9'h001 : duty_raw; // R17
  wire        cnt_wrap = ({1'b0, ref_cnt} == div_last);
  wire  [6:0] next_ref_cnt = cnt_wrap ? 7'h00 : ref_cnt + 7'h01;
  wire        next_ref_q   = ({2'b00, next_ref_cnt} < duty_thr);

  // sleep freezes counters and levels instead of gating the clock
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ref_cnt <= 7'h00;
      ref_q   <= 1'b0;
    end
    else if (sleep_i)
    begin
      ref_cnt <= ref_cnt; // R22
      ref_q   <= ref_q;
    end
    else if (!ref_en)
    begin
      ref_cnt <= 7'h00; // R14
      ref_q   <= 1'b0;
    end
    else
    begin
      ref_cnt <= next_ref_cnt; // R13
      ref_q   <= next_ref_q;
    end
  end

  // undivided mode passes the source clock so its duty is kept; glitch-free
  // only while the enable and duty bits stay still
  wire pass_src  = (ref_div == 3'b000) & ref_en & (ref_dc != 2'b00) & ~sleep_i;
  wire ref_clock = pass_src ? sys_clk_i : ref_q; // R16
  assign modulator_clk_o = ref_clock & ref_en & (ref_dc != 2'b00); // R25 R13

  // instruction clock, system clock divided by four
  logic [1:0] instr_cnt;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      instr_cnt <= 2'b00;
    else if (!sleep_i)
      instr_cnt <= instr_cnt + 2'b01;
  end
  wire instruction_clock_output = instr_cnt[1];

  // pin ownership: clock-out beats crystal pin beats reference clock
  wire crystal_mode = (config_osc_mode_i == `OSCREF_MODE_LP) |
                      (config_osc_mode_i == `OSCREF_MODE_XT) |
                      (config_osc_mode_i == `OSCREF_MODE_HS);
  wire ref_on_pin   = ref_en & ref_oe & ~crystal_mode; // R14 R20
  assign reference_clock_pin_o    = config_clock_out_enable_i ?
                                    instruction_clock_output : ref_clock & ref_on_pin; // R21
  assign reference_clock_pin_oe_o = config_clock_out_enable_i | ref_on_pin; // R21
  assign refclk_slew_limit_o      = refclk_control[`OSCREF_REF_SLEW]; // R18

  // checks
  default clocking chk_clk @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_pll_forced_on: assert property (config_pll_enable_i |-> clk_sel_o.pll_enable) // R1
    else $error("pll not forced on by config");
  chk_pll_soft_ctl: assert property (
    (bus_wr && hit_control && !config_pll_enable_i) ##1 !config_pll_enable_i
      |-> clk_sel_o.pll_enable == $past(wr_byte[7])) // R2
    else $error("software pll bit not followed");
  chk_hf_range: assert property (clk_sel_o.freq_code[3] |-> clk_sel_o.int_src == OSCREF_INT_HF) // R3
    else $error("high codes not on hf source");
  chk_mf_codes: assert property ((clk_sel_o.freq_code inside {4'h7, 4'h6, 4'h5, 4'h4, 4'h2})
    |-> clk_sel_o.int_src == OSCREF_INT_MF) // R4
    else $error("medium codes not on mf source");
  chk_lf_codes: assert property (clk_sel_o.freq_code[3:1] == 3'b000
    |-> clk_sel_o.int_src == OSCREF_INT_LF) // R5
    else $error("low codes not on lf source");
  chk_sys_select: assert property (clk_select == 2'b01 |-> clk_sel_o.sys_src == OSCREF_SRC_TIMER1) // R6
    else $error("timer1 select not decoded");
  chk_t1_ready_idle: assert property (!t1_enable |-> osc_status[7]) // R7
    else $error("timer1 ready low while disabled");
  chk_pin_gating: assert property (reference_clock_pin_oe_o && !config_clock_out_enable_i
    |-> ref_en && ref_oe && !crystal_mode) // R14
    else $error("pin driven without enables");
  chk_instruction_clock_output_prio: assert property (config_clock_out_enable_i
    |-> reference_clock_pin_o == instr_cnt[1]) // R21
    else $error("instruction clock not on pin");
  chk_sleep_hold: assert property (sleep_i ##1 sleep_i |-> $stable(ref_q) && $stable(ref_cnt)) // R22
    else $error("reference clock moved in sleep");
  chk_div8_period: assert property (
    (ref_en && ref_div == 3'h3 && !sleep_i && ref_cnt == 7'h07) |=> ref_cnt == 7'h00) // R23
    else $error("divide by eight wraps wrong");
  chk_mod_idle_low: assert property (!ref_en || ref_dc == 2'b00 |-> !modulator_clk_o) // R25
    else $error("modulator clock not low");
  chk_bus_ack: assert property (bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not single cycle");

  // pll and status flags; every status bit is a live view, nothing sticky
  chk_pll_follow_soft: assert property ( // R2
    !config_pll_enable_i |-> clk_sel_o.pll_enable == soft_pll)
    else $error("pll enable not following software bit");

  chk_pll_ready_gate: assert property ( // R8
    !clk_sel_o.pll_enable |-> !osc_status[6])
    else $error("pll ready while pll disabled");

  chk_pll_ready_on: assert property ( // R8
    clk_sel_o.pll_enable && osc_state_i.pll_locked |-> osc_status[6])
    else $error("pll ready missing");

  chk_t1_ready_live: assert property ( // R7
    t1_enable |-> osc_status[7] == osc_state_i.timer1_osc_ready)
    else $error("timer1 ready not live while enabled");

  chk_startup_flag: assert property ( // R9
    osc_status[5] == osc_state_i.on_config_clock)
    else $error("start-up status flag wrong");

  chk_hf_ready_flag: assert property ( // R10
    osc_status[4] == osc_state_i.high_freq_osc_ready)
    else $error("hf ready flag wrong");

  chk_mf_ready_flag: assert property ( // R10
    osc_status[2] == osc_state_i.mid_freq_osc_ready)
    else $error("mf ready flag wrong");

  chk_lf_ready_flag: assert property ( // R10
    osc_status[1] == osc_state_i.low_freq_osc_ready)
    else $error("lf ready flag wrong");

  chk_hf_lock_flag: assert property ( // R11
    osc_status[3] == osc_state_i.high_freq_osc_locked)
    else $error("hf locked flag wrong");

  chk_hf_stable_flag: assert property ( // R11
    osc_status[0] == osc_state_i.high_freq_osc_stable)
    else $error("hf stable flag wrong");

  // source decode corners; tuning and slew routing
  chk_hf_31k_code: assert property ( // R5
    clk_sel_o.freq_code == 4'h3 |-> clk_sel_o.int_src == OSCREF_INT_HF)
    else $error("code 0011 not on hf source");

  chk_intosc_select: assert property ( // R6
    clk_select[1] |-> clk_sel_o.sys_src == OSCREF_SRC_INTOSC)
    else $error("internal select not decoded");

  chk_config_select: assert property ( // R6
    clk_select == 2'b00 |-> clk_sel_o.sys_src == OSCREF_SRC_CONFIG)
    else $error("config select not decoded");

  chk_tuning_route: assert property ( // R12
    clk_sel_o.freq_tuning_offset == osc_tuning[5:0])
    else $error("tuning offset not routed");

  chk_tuning_upper: assert property ( // R12
    osc_tuning[7:6] == 2'b00)
    else $error("tuning upper bits set");

  chk_slew_route: assert property ( // R18
    refclk_slew_limit_o == refclk_control[`OSCREF_REF_SLEW])
    else $error("slew limit not routed");

  // reference divider and duty; instruction clock held in sleep
  chk_disabled_idle: assert property ( // R14
    !ref_en && !sleep_i |=> ref_cnt == 7'h00 && !ref_q)
    else $error("divider runs while disabled");

  chk_div2_period: assert property ( // R23
    (ref_en && ref_div == 3'h1 && !sleep_i && ref_cnt == 7'h01) |=> ref_cnt == 7'h00)
    else $error("divide by two wraps wrong");

  chk_div128_wrap: assert property ( // R23
    (ref_en && ref_div == 3'h7 && !sleep_i && ref_cnt == 7'h7f) |=> ref_cnt == 7'h00)
    else $error("divide by 128 wraps wrong");

  chk_duty_zero_low: assert property ( // R24
    ref_dc == 2'b00 && !sleep_i |=> !ref_q)
    else $error("zero duty gives a high level");

  chk_duty_half_div4: assert property ( // R24
    (ref_en && !sleep_i && ref_div == 3'h2 && ref_dc == 2'b10 && ref_cnt == 7'h01)
      |=> !ref_q)
    else $error("half duty at divide by four wrong");

  chk_duty_high_start: assert property ( // R24
    (ref_en && !sleep_i && ref_dc != 2'b00 && cnt_wrap) |=> ref_q)
    else $error("period does not start high");

  chk_mod_divided: assert property ( // R13
    ref_div != 3'h0 |-> modulator_clk_o == (ref_q && ref_en && ref_dc != 2'b00))
    else $error("modulator feed differs from divider");

  chk_sleep_instr: assert property ( // R22
    sleep_i |=> $stable(instr_cnt))
    else $error("instruction clock moved in sleep");

  // pin ownership
  chk_crystal_pin: assert property ( // R20
    crystal_mode && !config_clock_out_enable_i |-> !reference_clock_pin_oe_o)
    else $error("pin driven in crystal mode");

  chk_instruction_clock_output_oe: assert property ( // R21
    config_clock_out_enable_i |-> reference_clock_pin_oe_o)
    else $error("clock-out pin not driven");

  chk_pin_low_off: assert property ( // R14
    !reference_clock_pin_oe_o |-> !reference_clock_pin_o)
    else $error("pin level high while not driven");

  // bus side
  chk_ack_after_req: assert property (
    wb_ack_o |-> $past(bus_req))
    else $error("ack without a request");

  chk_rd_upper_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");

  chk_control_write: assert property ( // R4
    bus_wr && hit_control |=> osc_control == ($past(wr_byte) & `OSCREF_CTL_MASK))
    else $error("control write not stored");

endmodule // oscref_ctrl

// *** oscref_ctrl_bench.sv ***
// self-checking bench of the oscillator select and reference clock block
`timescale 1ns/1ps
`include "oscref_regs.svh"
module oscref_ctrl_bench;
  import oscref_pkg::*;
  logic              sys_clk_i, rst_b_i, cyc, stb, we, cfg_pll, cfg_cko, slp;
  logic [7:0]        adr;
  logic [31:0]       wdat, rdat;
  logic [2:0]        mode;
  oscref_osc_state_t st;
  oscref_clk_sel_t   cs;
  wire  [31:0]       dat_o;
  wire               ack, pin, pin_oe, slew, mclk;
  wire  [7:0]        m_per, m_hi, p_per, p_hi;
  int                fail_count = 0;
  int                n_compared = 0;

  oscref_ctrl DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .config_pll_enable_i(cfg_pll), .config_clock_out_enable_i(cfg_cko),
    .config_osc_mode_i(mode), .osc_state_i(st), .sleep_i(slp), .clk_sel_o(cs),
    .reference_clock_pin_o(pin), .reference_clock_pin_oe_o(pin_oe),
    .refclk_slew_limit_o(slew), .modulator_clk_o(mclk));
  // one meter on the modulator feed, one on the pin
  oscref_clk_meter MOD (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sig_i(mclk),
    .per_o(m_per), .hi_o(m_hi));
  oscref_clk_meter PIN (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sig_i(pin & pin_oe),
    .per_o(p_per), .hi_o(p_hi));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // classic cycle; waits for ack under a bound, never assumes latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    {cyc, stb, we} <= 3'b000;
    chk(ack, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rdat, {24'h0, e});
  endtask

  // the modulator feed must sit at one level for eight cycles
  task automatic hold(input logic e);
    repeat (8) @(negedge sys_clk_i) chk(mclk, e);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic t_reset();
    rd(`OSCREF_OFS_CONTROL, 8'h38);
    rd(`OSCREF_OFS_TUNING, 8'h00);
    rd(`OSCREF_OFS_REFCLK, 8'h30);
    rd(`OSCREF_OFS_AUX, 8'h00);
    chk(slew, 1'b1);
    chk(mclk, 1'b0);
    chk(pin_oe, 1'b0);
    wb(1'b1, 8'h14, 8'hff);
    rd(8'h14, 8'h00);
  endtask

  function automatic oscref_int_src_t exp_int(input logic [3:0] c);
    if (c[3] || c == 4'h3) return OSCREF_INT_HF;
    if (c[3:1] == 3'h0) return OSCREF_INT_LF;
    return OSCREF_INT_MF;
  endfunction

  task automatic t_ctrl();
    for (int c = 0; c < 16; c++)
    begin
      wb(1'b1, `OSCREF_OFS_CONTROL, {1'b0, c[3:0], 3'h0});
      chk(cs.int_src, exp_int(c[3:0]));
      chk(cs.freq_code, c[3:0]);
    end
    for (int s = 0; s < 4; s++)
    begin
      wb(1'b1, `OSCREF_OFS_CONTROL, {6'h0e, s[1:0]});
      chk(cs.sys_src, s[1] ? OSCREF_SRC_INTOSC : s[0] ? OSCREF_SRC_TIMER1
          : OSCREF_SRC_CONFIG);
      rd(`OSCREF_OFS_CONTROL, {6'h0e, s[1:0]});
    end
    wb(1'b1, `OSCREF_OFS_CONTROL, 8'hb8);
    chk(cs.pll_enable, 1'b1);
    wb(1'b1, `OSCREF_OFS_CONTROL, 8'h38);
    chk(cs.pll_enable, 1'b0);
    cfg_pll <= 1'b1;
    wait_clk(2);
    chk(cs.pll_enable, 1'b1);
    wb(1'b1, `OSCREF_OFS_TUNING, 8'hff);
    rd(`OSCREF_OFS_TUNING, 8'h3f);
    wb(1'b1, `OSCREF_OFS_TUNING, 8'h20);
    chk(cs.freq_tuning_offset, 6'h20);
  endtask

  task automatic t_status();
    st <= 8'h00;
    rd(`OSCREF_OFS_STATUS, 8'h80);
    st <= 8'hff;
    wb(1'b1, `OSCREF_OFS_STATUS, 8'h00);
    rd(`OSCREF_OFS_STATUS, 8'hff);
    wb(1'b1, `OSCREF_OFS_AUX, 8'h01);
    st <= 8'h7e;
    rd(`OSCREF_OFS_STATUS, 8'h7e);
  endtask

  task automatic per(input logic [7:0] v, input logic [7:0] p, input logic [7:0] h);
    wb(1'b1, `OSCREF_OFS_REFCLK, v);
    wait_clk(300);
    chk(m_per, p);
    chk(m_hi, h);
  endtask

  task automatic t_refclk();
    logic v;
    per(8'hd2, 8'h04, 8'h02);
    chk(p_per, 8'h04);
    chk(slew, 1'b0);
    per(8'hdb, 8'h08, 8'h06);
    per(8'hcf, 8'h80, 8'h20);
    per(8'hd1, 8'h02, 8'h01);
    slp <= 1'b1;
    @(negedge sys_clk_i);
    v = mclk;
    hold(v);
    slp <= 1'b0;
    mode <= `OSCREF_MODE_XT;
    wait_clk(8);
    chk(pin_oe, 1'b0);
    chk(m_per, 8'h02);
    cfg_cko <= 1'b1;
    wait_clk(20);
    chk(pin_oe, 1'b1);
    chk(p_per, 8'h04);
    {cfg_cko, mode} <= 4'h3;
    per(8'hc1, 8'h02, 8'h01);
    hold(1'b0);
    wb(1'b1, `OSCREF_OFS_REFCLK, 8'h52);
    hold(1'b0);
    chk(pin_oe, 1'b0);
    wb(1'b1, `OSCREF_OFS_REFCLK, 8'hd2);
    rst_b_i <= 1'b0;
    wait_clk(2);
    rst_b_i <= 1'b1;
    rd(`OSCREF_OFS_REFCLK, 8'h30);
    hold(1'b0);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    {rst_b_i, cyc, stb, we, cfg_pll, cfg_cko, slp} = '0;
    {adr, wdat, st} = '0;
    mode = 3'h3;
    wait_clk(12);
    rst_b_i <= 1'b1;
    t_reset();
    t_ctrl();
    t_status();
    t_refclk();
    stop_test();
  end

  // cut a hang short well past the expected run
  initial
  begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule // oscref_ctrl_bench

// *** oscref_pkg.sv ***
// types shared by the oscillator select and reference clock block
package oscref_pkg;

  // system clock source picked by the select field
  typedef enum logic [2:0] {
    OSCREF_SRC_CONFIG = 3'b001,
    OSCREF_SRC_TIMER1 = 3'b010,
    OSCREF_SRC_INTOSC = 3'b100
  } oscref_sys_src_t;

  // internal oscillator feeding the divider chain
  typedef enum logic [2:0] {
    OSCREF_INT_HF = 3'b001,
    OSCREF_INT_MF = 3'b010,
    OSCREF_INT_LF = 3'b100
  } oscref_int_src_t;

  // readiness inputs from the analog oscillators
  typedef struct packed {
    logic timer1_osc_ready;
    logic pll_locked;
    logic on_config_clock;
    logic high_freq_osc_ready;
    logic high_freq_osc_locked;
    logic mid_freq_osc_ready;
    logic low_freq_osc_ready;
    logic high_freq_osc_stable;
  } oscref_osc_state_t;

  // clock selection handed to the clock tree
  typedef struct packed {
    oscref_sys_src_t sys_src;
    oscref_int_src_t int_src;
    logic [3:0]      freq_code;
    logic            pll_enable;
    logic [5:0]      freq_tuning_offset;
  } oscref_clk_sel_t;

endpackage

// *** oscref_regs.svh ***
// register offsets, field positions, reset values and codes of the oscillator block
`ifndef OSCREF_REGS_SVH
`define OSCREF_REGS_SVH

// word-aligned byte offsets on the register bus
`define OSCREF_OFS_CONTROL   8'h00
`define OSCREF_OFS_STATUS    8'h04
`define OSCREF_OFS_TUNING    8'h08
`define OSCREF_OFS_REFCLK    8'h0c
`define OSCREF_OFS_AUX       8'h10

// reset values
`define OSCREF_RST_CONTROL   8'h38
`define OSCREF_RST_TUNING    8'h00
`define OSCREF_RST_REFCLK    8'h30
`define OSCREF_RST_AUX       8'h00

// oscillator control fields
`define OSCREF_CTL_SPLL      7
`define OSCREF_CTL_FREQ_HI   6
`define OSCREF_CTL_FREQ_LO   3
`define OSCREF_CTL_SCS_HI    1
`define OSCREF_CTL_SCS_LO    0
`define OSCREF_CTL_MASK      8'hfb

// tuning field
`define OSCREF_TUN_MASK      8'h3f

// reference clock control fields
`define OSCREF_REF_EN        7
`define OSCREF_REF_OE        6
`define OSCREF_REF_SLEW      5
`define OSCREF_REF_DC_HI     4
`define OSCREF_REF_DC_LO     3
`define OSCREF_REF_DIV_HI    2
`define OSCREF_REF_DIV_LO    0

// auxiliary control fields
`define OSCREF_AUX_T1EN      0
`define OSCREF_AUX_MASK      8'h01

// frequency select codes
`define OSCREF_FREQ_HF_31K   4'h3
`define OSCREF_FREQ_MF_31K   4'h2

// configuration oscillator mode codes for the crystal modes
`define OSCREF_MODE_LP       3'h0
`define OSCREF_MODE_XT       3'h1
`define OSCREF_MODE_HS       3'h2

`endif
